/* File: rtl/maac_ctrl.v */
`timescale 1ns/100ps
`include "maac_regs.vh"
// What this block does
// R1: holds a 22-bit display memory base per aperture; upper bits reserved.
// R2: base low two bits ignored on write, read back zero.
// R3: third base pointer at 08 exists only in first silicon revision.
// R4: mode bits 6:4 pick linear layout per aperture, 0 keeps display mode.
// R5: linear layout forces plane mask and bit mask all ones, plain modes.
// R6: route bits 2:0 send aperture to graphics path (0) or accelerator (1).
// R7: accelerator registers decode as non-queued 30-3a and queued 80-ae.
// R8: software terminates by setting terminate, polling busy clear, clearing it.
// R9: termination puts accelerator back to its power-on state.
// R10: host write override lets writes into accelerator; cleared by reset, terminate.
// R11: host read override lets reads from accelerator; cleared by reset, terminate.
// R12: flush bit toggled 0-1-0 flushes pipeline; resets to zero.
// R13: software suspends by setting suspend, waiting status clear, clearing it.
// R14: first revision treats override and flush bits as reserved.
module maac_ctrl #(
   parameter NUM_AP = 3,
   parameter FIRST_REV = 1'b0
) (
   // clock and reset
   input wire clk_in,
   input wire rst_in,
   // host register access, 32-bit word with byte enables, same clock domain
   input wire [7:0] reg_addr_in,
   input wire [31:0] reg_wdata_in,
   input wire [3:0] reg_be_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output reg [31:0] reg_rdata_out,
   output reg reg_ack_out,
   // aperture accesses from host
   input wire [NUM_AP-1:0] mem_wr_in,
   input wire [NUM_AP-1:0] mem_rd_in,
   // programmed vga mode fields
   input wire [3:0] plane_mask_in,
   input wire [7:0] bit_mask_in,
   // accelerator status
   input wire read_status_busy_in,
   input wire suspend_in_progress_in,
   input wire [31:0] accel_rdata_in,
   // aperture bases and modes
   output reg [`MAAC_BASE_W*NUM_AP-1:0] aperture_base_out,
   output reg [4*NUM_AP-1:0] eff_plane_mask_out,
   output reg [8*NUM_AP-1:0] eff_bit_mask_out,
   output reg [NUM_AP-1:0] eff_plain_mode_out,
   // routed accesses
   output reg [NUM_AP-1:0] to_accel_wr_out,
   output reg [NUM_AP-1:0] to_accel_rd_out,
   output reg [NUM_AP-1:0] to_gfx_out,
   // accelerator register strobes
   output reg accel_nq_wr_out,
   output reg accel_q_wr_out,
   output reg accel_rd_out,
   output reg [7:0] accel_addr_out,
   output reg [31:0] accel_wdata_out,
   output reg [3:0] accel_be_out,
   // accelerator control
   output reg accel_reset_out,
   output reg suspend_op_out,
   output reg pipeline_flush_out,
   output reg [NUM_AP-1:0] accel_apert_hold_out,
   output reg status_poll_out
);
   reg [`MAAC_BASE_W-1:0] base_q [0:NUM_AP-1];
   reg [7:0] mode_q;
   reg [7:0] st_q;
   reg flush_prev_q;
   reg [7:0] st_d;
   reg [31:0] rdata_d;
   integer k;
   integer j;
   // offsets kept at full width so word and lane fields are cut on purpose
   localparam [7:0] MODE_OFF = `MAAC_OFF_MODE;
   localparam [7:0] ST_OFF = `MAAC_OFF_SUSTERM;
   localparam [1:0] MODE_LANE = MODE_OFF[1:0];
   localparam [1:0] ST_LANE = ST_OFF[1:0];

   wire [NUM_AP-1:0] linear_layout_select = mode_q[`MAAC_LIN_LSB+NUM_AP-1:`MAAC_LIN_LSB];
   wire [NUM_AP-1:0] aperture_route_select = mode_q[`MAAC_ROUTE_LSB+NUM_AP-1:`MAAC_ROUTE_LSB];
   wire terminate_op = st_q[`MAAC_ST_TERM];
   wire host_write_override = st_q[`MAAC_ST_HWO];
   wire host_read_override = st_q[`MAAC_ST_HRO];
   wire pipeline_flush = st_q[`MAAC_ST_FLUSH];
   wire [7:0] st_mask = FIRST_REV ? `MAAC_ST_MASK_REVA : `MAAC_ST_MASK; // R14

   // decode of an aligned word index for base pointer n
   function base_hit;
      input [7:0] addr;
      input integer n;
      begin
         base_hit = (addr[7:2] == n[5:0]) &&
            ((n != 2) || FIRST_REV); // R3
      end
   endfunction

   function in_range;
      input [7:0] addr;
      input [7:0] lo;
      input [7:0] hi;
      begin
         in_range = (addr >= lo) && (addr <= hi); // R7
      end
   endfunction

   // byte lane within the word holding a byte register
   function [7:0] lane_byte;
      input [31:0] w;
      input [1:0] lane;
      begin
         lane_byte = w[8*lane +: 8];
      end
   endfunction

   wire mode_hit = (reg_addr_in[7:2] == MODE_OFF[7:2]) &&
      reg_be_in[MODE_LANE];
   wire st_hit = (reg_addr_in[7:2] == ST_OFF[7:2]) &&
      reg_be_in[ST_LANE];
   wire nq_sel = in_range(reg_addr_in, `MAAC_NQ_LO, `MAAC_NQ_HI); // R7
   wire q_sel = in_range(reg_addr_in, `MAAC_Q_LO, `MAAC_Q_HI); // R7
   wire st_word = (reg_addr_in[7:2] == ST_OFF[7:2]);

   wire [4*NUM_AP-1:0] r_plane;
   wire [8*NUM_AP-1:0] r_bmask;
   wire [NUM_AP-1:0] r_plain;
   wire [NUM_AP-1:0] r_awr;
   wire [NUM_AP-1:0] r_ard;
   wire [NUM_AP-1:0] r_gfx;

   maac_route #(
      .NUM_AP(NUM_AP)
   ) u_route (
      .linear_layout_select_in(linear_layout_select),
      .aperture_route_select_in(aperture_route_select),
      .host_write_override_in(host_write_override),
      .host_read_override_in(host_read_override),
      .plane_mask_in(plane_mask_in),
      .bit_mask_in(bit_mask_in),
      .mem_wr_in(mem_wr_in),
      .mem_rd_in(mem_rd_in),
      .eff_plane_mask_out(r_plane),
      .eff_bit_mask_out(r_bmask),
      .eff_plain_mode_out(r_plain),
      .to_accel_wr_out(r_awr),
      .to_accel_rd_out(r_ard),
      .to_gfx_out(r_gfx)
   );

   // suspend/terminate next value
   always @*
   begin
      st_d = st_q;
      if (reg_wr_in && st_hit)
      begin
         st_d = lane_byte(reg_wdata_in, ST_LANE) & st_mask;
      end
      // overrides drop while terminate is held, even if written at once
      if (st_d[`MAAC_ST_TERM])
      begin
         st_d[`MAAC_ST_HWO] = 1'b0; // R10
         st_d[`MAAC_ST_HRO] = 1'b0; // R11
      end
   end

   // read mux
   always @*
   begin
      rdata_d = 32'h00000000;
      for (k = 0; k < NUM_AP; k = k + 1)
      begin
         if (base_hit(reg_addr_in, k))
         begin
            rdata_d[`MAAC_BASE_W-1:0] = {base_q[k][`MAAC_BASE_W-1:2], 2'b00}; // R1 R2
         end
      end
      if (reg_addr_in[7:2] == MODE_OFF[7:2])
      begin
         rdata_d[8*MODE_LANE +: 8] = mode_q & `MAAC_MODE_MASK;
      end
      if (st_word)
      begin
         rdata_d = accel_rdata_in;
         rdata_d[7:0] = st_q;
      end
      else if (nq_sel || q_sel)
      begin
         rdata_d = accel_rdata_in;
      end
   end

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         for (j = 0; j < NUM_AP; j = j + 1)
         begin
            base_q[j] <= `MAAC_BASE_RST;
         end
         mode_q <= `MAAC_MODE_RST;
         st_q <= `MAAC_ST_RST; // R10 R11 R12
         flush_prev_q <= 1'b0;
         reg_rdata_out <= 32'h00000000;
         reg_ack_out <= 1'b0;
         aperture_base_out <= {`MAAC_BASE_W*NUM_AP{1'b0}};
         eff_plane_mask_out <= {4*NUM_AP{1'b0}};
         eff_bit_mask_out <= {8*NUM_AP{1'b0}};
         eff_plain_mode_out <= {NUM_AP{1'b0}};
         to_accel_wr_out <= {NUM_AP{1'b0}};
         to_accel_rd_out <= {NUM_AP{1'b0}};
         to_gfx_out <= {NUM_AP{1'b0}};
         accel_reset_out <= 1'b0;
         suspend_op_out <= 1'b0;
         pipeline_flush_out <= 1'b0;
         accel_apert_hold_out <= {NUM_AP{1'b0}};
         status_poll_out <= 1'b0;
      end
      else
      begin
         for (j = 0; j < NUM_AP; j = j + 1)
         begin
            if (reg_wr_in && base_hit(reg_addr_in, j))
            begin
               // low two bits never stored so the base stays aligned
               if (reg_be_in[0])
               begin
                  base_q[j][7:2] <= reg_wdata_in[7:2]; // R2
               end
               if (reg_be_in[1])
               begin
                  base_q[j][15:8] <= reg_wdata_in[15:8]; // R1
               end
               // lane 3 is reserved, so it is never stored
               if (reg_be_in[2])
               begin
                  base_q[j][21:16] <= reg_wdata_in[21:16]; // R1
               end
            end
         end
         if (reg_wr_in && mode_hit)
         begin
            mode_q <= lane_byte(reg_wdata_in, MODE_LANE) & `MAAC_MODE_MASK; // R4 R6
         end
         st_q <= st_d;
         flush_prev_q <= pipeline_flush;
         reg_ack_out <= reg_wr_in | reg_rd_in;
         reg_rdata_out <= reg_rd_in ? rdata_d : 32'h00000000;
         for (j = 0; j < NUM_AP; j = j + 1)
         begin
            aperture_base_out[`MAAC_BASE_W*j +: `MAAC_BASE_W] <=
               {base_q[j][`MAAC_BASE_W-1:2], 2'b00}; // R1
         end
         eff_plane_mask_out <= r_plane; // R5
         eff_bit_mask_out <= r_bmask; // R5
         eff_plain_mode_out <= r_plain; // R4
         to_accel_wr_out <= r_awr; // R6 R10
         to_accel_rd_out <= r_ard; // R6 R11
         to_gfx_out <= r_gfx; // R6
         // level held while software keeps terminate set
         accel_reset_out <= terminate_op; // R9
         suspend_op_out <= st_q[`MAAC_ST_SUSP];
         // one pulse on the falling step of a 0-1-0 toggle
         pipeline_flush_out <= flush_prev_q & ~pipeline_flush; // R12
         accel_apert_hold_out <= {NUM_AP{terminate_op}} & aperture_route_select;
         // which status bit software must wait on
         status_poll_out <= (terminate_op | (FIRST_REV & st_q[`MAAC_ST_SUSP])) ?
            read_status_busy_in :
            (st_q[`MAAC_ST_SUSP] & suspend_in_progress_in); // R8 R13
      end
   end

   // accelerator register strobes: one cycle behind the host access
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         accel_nq_wr_out <= 1'b0;
         accel_q_wr_out <= 1'b0;
         accel_rd_out <= 1'b0;
         accel_addr_out <= 8'h00;
         accel_wdata_out <= 32'h00000000;
         accel_be_out <= 4'h0;
      end
      else
      begin
         accel_nq_wr_out <= reg_wr_in & nq_sel; // R7
         accel_q_wr_out <= reg_wr_in & q_sel; // R7
         accel_rd_out <= reg_rd_in & (nq_sel | q_sel); // R7
         // copies ride along with the strobe so the far side samples one word
         accel_addr_out <= reg_addr_in;
         accel_wdata_out <= reg_wdata_in;
         accel_be_out <= reg_be_in;
      end
   end
endmodule

/* File: rtl/maac_regs.vh */
`ifndef MAAC_REGS_VH
`define MAAC_REGS_VH
// byte offsets within the memory-mapped register space
`define MAAC_OFF_BASE0 8'h00
`define MAAC_OFF_BASE1 8'h04
`define MAAC_OFF_BASE2 8'h08
`define MAAC_OFF_MODE 8'h13
`define MAAC_OFF_SUSTERM 8'h30
`define MAAC_NQ_LO 8'h30
`define MAAC_NQ_HI 8'h3a
`define MAAC_Q_LO 8'h80
`define MAAC_Q_HI 8'hae
// field layout
`define MAAC_BASE_W 22
`define MAAC_LIN_LSB 4
`define MAAC_ROUTE_LSB 0
`define MAAC_ST_TERM 4
`define MAAC_ST_HWO 3
`define MAAC_ST_HRO 2
`define MAAC_ST_FLUSH 1
`define MAAC_ST_SUSP 0
`define MAAC_MODE_MASK 8'h77
`define MAAC_ST_MASK 8'h1f
`define MAAC_ST_MASK_REVA 8'h11
// forced values in linear layout
`define MAAC_PLANE_ALL 4'hf
`define MAAC_BITMASK_ALL 8'hff
// reset values
`define MAAC_BASE_RST 22'h000000
`define MAAC_MODE_RST 8'h00
`define MAAC_ST_RST 8'h00
`endif

/* File: rtl/maac_route.v */
`timescale 1ns/100ps
// per-aperture mode resolution: linear forcing and routing
module maac_route #(
   parameter NUM_AP = 3
) (
   // control
   input wire [NUM_AP-1:0] linear_layout_select_in,
   input wire [NUM_AP-1:0] aperture_route_select_in,
   input wire host_write_override_in,
   input wire host_read_override_in,
   // programmed vga mode fields and aperture accesses
   input wire [3:0] plane_mask_in,
   input wire [7:0] bit_mask_in,
   input wire [NUM_AP-1:0] mem_wr_in,
   input wire [NUM_AP-1:0] mem_rd_in,
   // effective values per aperture
   output wire [4*NUM_AP-1:0] eff_plane_mask_out,
   output wire [8*NUM_AP-1:0] eff_bit_mask_out,
   output wire [NUM_AP-1:0] eff_plain_mode_out,
   output wire [NUM_AP-1:0] to_accel_wr_out,
   output wire [NUM_AP-1:0] to_accel_rd_out,
   output wire [NUM_AP-1:0] to_gfx_out
);
   genvar i;
   generate
      for (i = 0; i < NUM_AP; i = i + 1)
      begin : g_ap
         assign eff_plane_mask_out[4*i+3:4*i] = linear_layout_select_in[i] ?
            `MAAC_PLANE_ALL : plane_mask_in; // R5
         assign eff_bit_mask_out[8*i+7:8*i] = linear_layout_select_in[i] ?
            `MAAC_BITMASK_ALL : bit_mask_in; // R5
         assign eff_plain_mode_out[i] = linear_layout_select_in[i]; // R5
         // overrides bypass routing only toward the accelerator
         assign to_accel_wr_out[i] = mem_wr_in[i] &
            (aperture_route_select_in[i] | host_write_override_in); // R6 R10
         assign to_accel_rd_out[i] = mem_rd_in[i] &
            (aperture_route_select_in[i] | host_read_override_in); // R6 R11
         assign to_gfx_out[i] = (mem_wr_in[i] | mem_rd_in[i]) &
            ~aperture_route_select_in[i]; // R6
      end
   endgenerate
endmodule

/* File: tb/maac_accel_model.sv */
`timescale 1ns/100ps
// accelerator status side: busy from a queued start until terminate or suspend has been held for SLOW cycles
module maac_accel_model #(
   parameter SLOW = 3
) (
   // clock and reset
   input wire clk_in,
   input wire rst_in,
   // from the block
   input wire accel_q_wr_out,
   input wire accel_reset_out,
   input wire suspend_op_out,
   // status back
   output logic read_status_busy_in,
   output logic suspend_in_progress_in,
   output logic [31:0] accel_rdata_in
);
   logic [3:0] wait_q;
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         read_status_busy_in <= 1'b0;
         suspend_in_progress_in <= 1'b0;
         wait_q <= 4'h0;
         accel_rdata_in <= 32'h0;
      end
      else
      begin
         // changes every cycle, flipping between two words, so a word one cycle stale never passes for fresh data
         accel_rdata_in <= ~accel_rdata_in + 32'h0135_79bd;
         wait_q <= (accel_reset_out || suspend_op_out) ? wait_q + 4'h1 : 4'h0;
         if (accel_q_wr_out)
            read_status_busy_in <= 1'b1;
         if (suspend_op_out && wait_q == 4'h0)
            suspend_in_progress_in <= read_status_busy_in;
         if (wait_q == SLOW)
         begin
            read_status_busy_in <= 1'b0;
            suspend_in_progress_in <= 1'b0;
         end
      end
   end
endmodule

/* File: tb/maac_ctrl_props.sv */
`timescale 1ns/100ps
module maac_ctrl_props #(
   parameter NUM_AP = 3,
   parameter FIRST_REV = 1'b0
) (
   // clock and reset
   input wire clk_in,
   input wire rst_in,
   // register port
   input wire [7:0] reg_addr_in,
   input wire [31:0] reg_wdata_in,
   input wire [3:0] reg_be_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [31:0] reg_rdata_out,
   input wire reg_ack_out,
   // aperture outputs
   input wire [22*NUM_AP-1:0] aperture_base_out,
   input wire [4*NUM_AP-1:0] eff_plane_mask_out,
   input wire [8*NUM_AP-1:0] eff_bit_mask_out,
   input wire [NUM_AP-1:0] eff_plain_mode_out,
   // accelerator side
   input wire accel_nq_wr_out,
   input wire accel_q_wr_out,
   input wire accel_reset_out,
   input wire pipeline_flush_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   wire acc_wr = reg_wr_in;
   wire st_wr = reg_wr_in && reg_addr_in == 8'h30 && reg_be_in[0];
   ack_follow_a: assert property ((reg_wr_in || reg_rd_in) |=> reg_ack_out)
      else $error("access without ack");
   base_read_a: assert property (reg_rd_in && reg_addr_in < 8'h0c && reg_addr_in[1:0] == 2'h0
      |=> reg_rdata_out[31:22] == 10'h0 && reg_rdata_out[1:0] == 2'h0)
      else $error("base read shows reserved bits");
   base2_gone_a: assert property (!FIRST_REV && reg_rd_in && reg_addr_in == 8'h08
      |=> reg_rdata_out == 32'h0)
      else $error("third base present");
   mode_rsvd_a: assert property (reg_rd_in && reg_addr_in[7:2] == 6'h04
      |=> !reg_rdata_out[31] && !reg_rdata_out[27])
      else $error("mode reserved bits set");
   for (genvar i = 0; i < NUM_AP; i++)
   begin : g_ap
      lin_force_a: assert property (eff_plain_mode_out[i]
         |-> eff_plane_mask_out[4*i+:4] == 4'hf && eff_bit_mask_out[8*i+:8] == 8'hff)
         else $error("linear layout not forced");
      base_align_a: assert property (aperture_base_out[22*i+:2] == 2'h0)
         else $error("base not aligned");
   end
   q_decode_a: assert property (acc_wr && reg_addr_in >= 8'h80 && reg_addr_in <= 8'hae
      |=> accel_q_wr_out && !accel_nq_wr_out)
      else $error("queued write misdecoded");
   no_decode_a: assert property (acc_wr && (reg_addr_in < 8'h30 || reg_addr_in > 8'haf
      || (reg_addr_in > 8'h3b && reg_addr_in < 8'h80)) |=> !accel_q_wr_out && !accel_nq_wr_out)
      else $error("stray accelerator write");
   term_set_a: assert property (st_wr && reg_wdata_in[4] |-> ##[1:2] accel_reset_out)
      else $error("terminate not applied");
   term_clr_a: assert property (st_wr && !reg_wdata_in[4] |-> ##[1:2] !accel_reset_out)
      else $error("terminate not released");
   flush_pulse_a: assert property (pipeline_flush_out |=> !pipeline_flush_out)
      else $error("flush longer than a cycle");
   flush_c: cover property (pipeline_flush_out);
   term_c: cover property (accel_reset_out);
   lin_c: cover property (eff_plain_mode_out != 0);
endmodule
bind maac_ctrl maac_ctrl_props #(.NUM_AP(NUM_AP), .FIRST_REV(FIRST_REV)) u_props (
   .clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_be_in, .reg_wr_in, .reg_rd_in,
   .reg_rdata_out, .reg_ack_out, .aperture_base_out, .eff_plane_mask_out, .eff_bit_mask_out,
   .eff_plain_mode_out, .accel_nq_wr_out, .accel_q_wr_out, .accel_reset_out, .pipeline_flush_out);

/* File: tb/maac_ctrl_tb.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module maac_ctrl_tb;
   typedef struct packed { logic [7:0] a; logic [3:0] be; logic [31:0] d, m, e; } maac_row_t;
   logic clk_in, rst_in, reg_wr_in, reg_rd_in, reg_ack_out, accel_q_wr_out;
   logic accel_reset_out, suspend_op_out, pipeline_flush_out;
   logic read_status_busy_in, suspend_in_progress_in;
   logic [7:0] reg_addr_in, bit_mask_in;
   logic [3:0] reg_be_in, plane_mask_in;
   logic [31:0] reg_wdata_in, reg_rdata_out, accel_rdata_in, rdv;
   logic [2:0] mem_wr_in, mem_rd_in, eff_plain_mode_out, to_accel_wr_out, to_accel_rd_out;
   logic [2:0] to_gfx_out, accel_apert_hold_out;
   logic accel_nq_wr_out, accel_rd_out, status_poll_out;
   logic [7:0] accel_addr_out;
   logic [3:0] accel_be_out;
   logic [31:0] accel_wdata_out;
   logic [65:0] aperture_base_out;
   logic [11:0] eff_plane_mask_out;
   logic [23:0] eff_bit_mask_out;
   int bad_count = 0, checks = 0, n;
   maac_row_t rows [6] = '{
      '{8'h00, 4'hf, 32'hffff_ffff, 32'hffff_ffff, 32'h003f_fffc},
      '{8'h04, 4'hf, 32'h1234_5677, 32'hffff_ffff, 32'h0034_5674},
      '{8'h08, 4'hf, 32'hffff_ffff, 32'hffff_ffff, 32'h0},
      '{8'h13, 4'h8, 32'hffff_ffff, 32'hff00_0000, 32'h7700_0000},
      '{8'h20, 4'hf, 32'hffff_ffff, 32'hffff_ffff, 32'h0},
      '{8'h30, 4'h1, 32'h0000_00ee, 32'h0000_00ff, 32'h0000_000e}};
   maac_ctrl #(.NUM_AP(3), .FIRST_REV(1'b0)) dut (.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
      .reg_be_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .reg_ack_out, .mem_wr_in, .mem_rd_in,
      .plane_mask_in, .bit_mask_in, .read_status_busy_in, .suspend_in_progress_in,
      .accel_rdata_in, .aperture_base_out, .eff_plane_mask_out, .eff_bit_mask_out,
      .eff_plain_mode_out, .to_accel_wr_out, .to_accel_rd_out, .to_gfx_out, .accel_nq_wr_out,
      .accel_q_wr_out, .accel_rd_out, .accel_addr_out, .accel_wdata_out, .accel_be_out,
      .accel_reset_out, .suspend_op_out, .pipeline_flush_out, .accel_apert_hold_out,
      .status_poll_out);
   maac_accel_model #(.SLOW(3)) u_model (.clk_in, .rst_in, .accel_q_wr_out, .accel_reset_out,
      .suspend_op_out, .read_status_busy_in, .suspend_in_progress_in, .accel_rdata_in);
   task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge clk_in);
      {reg_wr_in, reg_rd_in, reg_addr_in, reg_be_in, reg_wdata_in} = {wr, !wr, a, be, d};
      @(negedge clk_in);
      {reg_wr_in, reg_rd_in} = 2'b00;
      `CHK(reg_ack_out, 1'b1)
      rdv = reg_rdata_out;
   endtask
   task automatic mem(input logic [2:0] w, input logic [2:0] r);
      @(negedge clk_in);
      {mem_wr_in, mem_rd_in} = {w, r};
      @(negedge clk_in);
      {mem_wr_in, mem_rd_in} = 6'h0;
   endtask
   // software side of terminate and suspend: wait for the status to drop
   task automatic poll(ref logic s);
      n = 0;
      while (s !== 1'b0 && n < 20)
      begin
         @(negedge clk_in);
         n++;
      end
      `CHK(n < 20, 1'b1)
   endtask
   task automatic complete_run;
      if (bad_count == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   initial
   begin
      #100000;
      bad_count++;
      complete_run();
   end
   initial
   begin
      rst_in = 1'b1;
      {reg_wr_in, reg_rd_in, reg_addr_in, reg_be_in, reg_wdata_in, mem_wr_in, mem_rd_in} = '0;
      {plane_mask_in, bit_mask_in} = {4'h3, 8'h0f};
      repeat (3) @(negedge clk_in);
      rst_in = 1'b0;
      foreach (rows[i])
      begin
         acc(1'b1, rows[i].a, rows[i].be, rows[i].d);
         acc(1'b0, rows[i].a, rows[i].be, 32'h0);
         `CHK(rdv & rows[i].m, rows[i].e)
      end
      // second reset in mid-run with mode, override and flush bits set, terminate and suspend clear
      rst_in = 1'b1;
      repeat (3) @(negedge clk_in);
      `CHK({aperture_base_out, eff_plain_mode_out, pipeline_flush_out}, 70'h0)
      rst_in = 1'b0;
      acc(1'b0, 8'h13, 4'h8, 32'h0);
      `CHK(rdv, 32'h0)
      acc(1'b0, 8'h30, 4'h1, 32'h0);
      `CHK(rdv[7:0], 8'h00)
      acc(1'b1, 8'h13, 4'h8, 32'h1100_0000);
      @(negedge clk_in);
      `CHK({eff_plain_mode_out, eff_plane_mask_out, eff_bit_mask_out},
         {3'b001, 12'h33f, 24'h0f0fff})
      mem(3'b011, 3'b100);
      `CHK({to_accel_wr_out, to_accel_rd_out, to_gfx_out}, 9'b001_000_110)
      acc(1'b1, 8'h30, 4'h1, 32'h0c);
      `CHK(accel_nq_wr_out, 1'b1)
      mem(3'b010, 3'b010);
      `CHK({to_accel_wr_out, to_accel_rd_out}, 6'b010_010)
      acc(1'b1, 8'h80, 4'hf, 32'h1);
      `CHK(accel_q_wr_out, 1'b1)
      `CHK({accel_nq_wr_out, accel_addr_out, accel_wdata_out, accel_be_out},
         {1'b0, 8'h80, 32'h1, 4'hf})
      acc(1'b1, 8'h30, 4'h1, 32'h1c);
      @(negedge clk_in);
      `CHK(accel_reset_out, 1'b1)
      `CHK({accel_apert_hold_out, status_poll_out}, 4'b0011)
      poll(read_status_busy_in);
      acc(1'b0, 8'h30, 4'h1, 32'h0);
      `CHK(rdv[7:0], 8'h10)
      `CHK(accel_rd_out, 1'b1)
      acc(1'b1, 8'h30, 4'h1, 32'h0);
      @(negedge clk_in);
      `CHK(accel_reset_out, 1'b0)
      acc(1'b1, 8'h30, 4'h1, 32'h2);
      acc(1'b1, 8'h30, 4'h1, 32'h0);
      n = 0;
      repeat (4)
      begin
         @(negedge clk_in);
         if (pipeline_flush_out === 1'b1)
            n++;
      end
      `CHK(n, 1)
      acc(1'b1, 8'h84, 4'hf, 32'h2);
      acc(1'b1, 8'h30, 4'h1, 32'h1);
      @(negedge clk_in);
      `CHK(suspend_op_out, 1'b1)
      poll(suspend_in_progress_in);
      acc(1'b1, 8'h30, 4'h1, 32'h0);
      @(negedge clk_in);
      `CHK(suspend_op_out, 1'b0)
      complete_run();
   end
endmodule
